//--- core/cwf_pkg.sv
// Shared constants for the comparator window/filter block.
// Assumes a 32-bit Avalon-MM register bus and one 250 MHz clock.
package cwf_pkg;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [3:0] CWF_CTRL_ADDR   = 4'h0;
	localparam logic [3:0] CWF_FILT_ADDR   = 4'h4;
	localparam logic [3:0] CWF_STATUS_ADDR = 4'h8;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CWF_CTRL_POWER_BIT  = 0;
	localparam int CWF_CTRL_WINDOW_BIT = 1;
	localparam int CWF_CTRL_STROBE_BIT = 2;
	localparam int CWF_CTRL_INVERT_BIT = 3;
	localparam int CWF_FILT_COUNT_LSB  = 0;
	localparam int CWF_FILT_INTV_LSB   = 8;
	localparam int CWF_STAT_COND_BIT   = 0;
	localparam int CWF_STAT_WIN_BIT    = 1;
	localparam int CWF_STAT_RISE_BIT   = 2;
	localparam int CWF_STAT_FALL_BIT   = 3;
	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int         CWF_COUNT_W    = 3;
	localparam int         CWF_INTV_W     = 8;
	localparam logic [3:0] CWF_CTRL_RESET = 4'h0;
	localparam logic [2:0] CWF_COUNT_RST  = 3'h0;
	localparam logic [7:0] CWF_INTV_RST   = 8'h00;
	localparam logic [2:0] CWF_COUNT_ONE  = 3'h1;
endpackage

//--- core/cwf_tick_gen.sv
// Sampling tick source for the filter stage.
// Assumes the strobe input is synchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none
module cwf_tick_gen #(
	parameter int INTV_W = 8
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic              clear_i,
	input  wire logic              strobe_sel_i,
	input  wire logic              strobe_i,
	input  wire logic [INTV_W-1:0] interval_i,
	output logic                   tick_o
);
	logic [INTV_W-1:0] div_q;
	logic              strobe_q;
	logic              div_tick;

	// ------------------------------------------------------------
	// Peripheral clock divider
	// ------------------------------------------------------------
	assign div_tick = (interval_i != '0) && (div_q >= interval_i - INTV_W'(1));

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			div_q <= '0;
		end else if (clear_i || strobe_sel_i || div_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + INTV_W'(1);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= strobe_i;
		end
	end

	// Strobe rising edge or divider wrap
	assign tick_o = strobe_sel_i ? (strobe_i & ~strobe_q) : div_tick;

	a_tick_spacing : assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick_o && !strobe_sel_i && interval_i > INTV_W'(1) && !clear_i) |=> !tick_o)
		else $error("internal tick repeated too soon");
	a_strobe_edge : assert property (@(posedge mclk_i) disable iff (rst_i)
		(strobe_sel_i && tick_o) |-> (strobe_i && !$past(strobe_i)))
		else $error("strobe tick without rising edge");
endmodule // cwf_tick_gen
`default_nettype wire

//--- core/cwf_agree_filter.sv
// Consecutive-sample agreement filter.
// Assumes sample_i is valid whenever tick_i is high.
`timescale 1ns/1ns
`default_nettype none
module cwf_agree_filter #(
	parameter int COUNT_W = 3
) (
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	input  wire logic               clear_i,
	input  wire logic               tick_i,
	input  wire logic               sample_i,
	input  wire logic [COUNT_W-1:0] need_i,
	output logic                    out_o
);
	logic [COUNT_W-1:0] agree_q;
	logic [COUNT_W-1:0] agree_d;

	assign agree_d = agree_q + COUNT_W'(1);

	// ------------------------------------------------------------
	// Agreement counter and held output
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			agree_q <= '0;
			out_o   <= 1'b0;
		end else if (clear_i) begin
			agree_q <= '0;
			out_o   <= 1'b0;
		end else if (tick_i) begin
			if (sample_i == out_o) begin
				agree_q <= '0;
			end else if (agree_d >= need_i) begin
				agree_q <= '0;
				out_o   <= sample_i;
			end else begin
				agree_q <= agree_d;
			end
		end
	end

	a_sampler_one : assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick_i && !clear_i && need_i == COUNT_W'(1)) |=> (out_o == $past(sample_i)))
		else $error("single-sample filter did not follow sample");
	a_multi_agree : assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick_i && !clear_i && need_i > COUNT_W'(1) && agree_q == '0) |=> $stable(out_o))
		else $error("multi-sample filter changed on first sample");
	a_clear_state : assert property (@(posedge mclk_i) disable iff (rst_i)
		clear_i |=> (!out_o && agree_q == '0))
		else $error("filter not reset by clear");
endmodule // cwf_agree_filter
`default_nettype wire

//--- core/cwf_top.sv
// Comparator output conditioning: polarity, window, sample and filter.
// Assumes raw compare, gate and strobe inputs synchronous to mclk_i.
// Operation
// - Filter ticks come from divided clock or external strobe, chosen by strobe select.
// - Filter output changes after count consecutive agreeing samples; count one just samples.
// - With strobe select set, sampling happens only on strobe rising edges.
// - With window enable set, compare result is taken only while gate is high.
// - Power-on cleared forces the raw compare result to zero.
// - Continuous mode bypasses window and filter; status follows combinationally.
// - In continuous mode conditioned and window-stage outputs are identical.
// - Sampled non-filtered mode captures window-stage output on each filter tick.
// - Sampled non-filtered mode is a plain sample-and-hold, window bypassed.
// - In sampled modes the path to the window-stage output is combinational.
// - Windowed mode updates window-stage output every clock while gate is high.
// - Windowed/resampled mode resamples windowed output every interval.
// - Windowed/filtered mode resamples and multi-sample filters the windowed output.
// - Strobe select 0 with count 0 resets the filter stage.
// - Count above one enables multi-sample filtering instead of sampling.
// - In windowed modes window-stage output holds while gate is low.
// - Filtered conditioned output comes straight from the filter flop, with no resynchronising stage.
// - Rising and falling edges of conditioned output set sticky event flags.
`timescale 1ns/1ns
`default_nettype none
module cwf_top #(
	parameter int COUNT_W = cwf_pkg::CWF_COUNT_W,
	parameter int INTV_W  = cwf_pkg::CWF_INTV_W
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        raw_compare_result_i,
	input  wire logic        window_gate_i,
	input  wire logic        sample_strobe_i,
	output logic             window_stage_output_o,
	output logic             conditioned_output_o,
	output logic             rise_event_flag_o,
	output logic             fall_event_flag_o
);
	logic               power_on_q;
	logic               window_en_q;
	logic               strobe_sel_q;
	logic               polarity_invert_q;
	logic [COUNT_W-1:0] filter_sample_count_q;
	logic [INTV_W-1:0]  filter_sample_interval_q;
	logic               win_hold_q;
	logic               cond_prev_q;
	logic               raw_gated;
	logic               polarity_out;
	logic               filter_in_use;
	logic               filter_clear;
	logic               sample_tick;
	logic               filter_out;
	logic               cont_mode;
	logic               rise_evt;
	logic               fall_evt;
	logic               bus_req;
	logic               bus_take;
	logic               wr_ctrl;
	logic               wr_filt;
	logic               wr_stat;
	logic               clr_rise;
	logic               clr_fall;

	// ------------------------------------------------------------
	// Compare path and mode decode
	// ------------------------------------------------------------
	assign raw_gated     = power_on_q & raw_compare_result_i;
	assign polarity_out  = raw_gated ^ polarity_invert_q;
	assign filter_in_use = power_on_q && (filter_sample_count_q != '0)
		&& (strobe_sel_q || filter_sample_interval_q != '0);
	assign cont_mode     = power_on_q && !window_en_q && !filter_in_use;
	assign filter_clear  = !strobe_sel_q && (filter_sample_count_q == '0);

	// Window latch runs on every clock while the gate is high
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			win_hold_q <= 1'b0;
		end else if (window_en_q && window_gate_i) begin
			win_hold_q <= polarity_out;
		end
	end

	// Unwindowed modes reach the window stage with no clocked element
	assign window_stage_output_o = window_en_q ? win_hold_q : polarity_out;
	// Bypass gives both outputs the same value; filter output is already a flop
	assign conditioned_output_o  = filter_in_use ? filter_out : window_stage_output_o;

	// ------------------------------------------------------------
	// Sampling clock and filter
	// ------------------------------------------------------------
	cwf_tick_gen #(
		.INTV_W (INTV_W)
	) u_tick (
		.mclk_i       (mclk_i),
		.rst_i        (rst_i),
		.clear_i      (filter_clear),
		.strobe_sel_i (strobe_sel_q),
		.strobe_i     (sample_strobe_i),
		.interval_i   (filter_sample_interval_q),
		.tick_o       (sample_tick)
	);

	// Resamples window-stage output in modes 3, 4, 6 and 7
	cwf_agree_filter #(
		.COUNT_W (COUNT_W)
	) u_filter (
		.mclk_i   (mclk_i),
		.rst_i    (rst_i),
		.clear_i  (filter_clear),
		.tick_i   (sample_tick),
		.sample_i (window_stage_output_o),
		.need_i   (filter_sample_count_q),
		.out_o    (filter_out)
	);

	// ------------------------------------------------------------
	// Edge events
	// ------------------------------------------------------------
	assign rise_evt = conditioned_output_o & ~cond_prev_q;
	assign fall_evt = ~conditioned_output_o & cond_prev_q;
	assign clr_rise = wr_stat && avs_writedata_i[cwf_pkg::CWF_STAT_RISE_BIT];
	assign clr_fall = wr_stat && avs_writedata_i[cwf_pkg::CWF_STAT_FALL_BIT];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cond_prev_q <= 1'b0;
		end else begin
			cond_prev_q <= conditioned_output_o;
		end
	end

	// Sticky, write one to clear; a new edge beats the clear
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rise_event_flag_o <= 1'b0;
			fall_event_flag_o <= 1'b0;
		end else begin
			if (rise_evt) begin
				rise_event_flag_o <= 1'b1;
			end else if (clr_rise) begin
				rise_event_flag_o <= 1'b0;
			end
			if (fall_evt) begin
				fall_event_flag_o <= 1'b1;
			end else if (clr_fall) begin
				fall_event_flag_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Avalon-MM slave, one wait state per access
	// ------------------------------------------------------------
	// Accepted write to one register address
	function automatic logic write_hit(
		input logic       take,
		input logic       write,
		input logic [3:0] addr,
		input logic [3:0] target
	);
		return take && write && (addr == target);
	endfunction

	assign bus_req  = avs_read_i | avs_write_i;
	assign bus_take = bus_req & ~avs_waitrequest_o;
	assign wr_ctrl  = write_hit(bus_take, avs_write_i, avs_address_i, cwf_pkg::CWF_CTRL_ADDR) && avs_byteenable_i[0];
	assign wr_filt  = write_hit(bus_take, avs_write_i, avs_address_i, cwf_pkg::CWF_FILT_ADDR);
	assign wr_stat  = write_hit(bus_take, avs_write_i, avs_address_i, cwf_pkg::CWF_STATUS_ADDR) && avs_byteenable_i[0];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			{polarity_invert_q, strobe_sel_q, window_en_q, power_on_q} <= cwf_pkg::CWF_CTRL_RESET;
		end else if (wr_ctrl) begin
			power_on_q        <= avs_writedata_i[cwf_pkg::CWF_CTRL_POWER_BIT];
			window_en_q       <= avs_writedata_i[cwf_pkg::CWF_CTRL_WINDOW_BIT];
			strobe_sel_q      <= avs_writedata_i[cwf_pkg::CWF_CTRL_STROBE_BIT];
			polarity_invert_q <= avs_writedata_i[cwf_pkg::CWF_CTRL_INVERT_BIT];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			filter_sample_count_q    <= COUNT_W'(cwf_pkg::CWF_COUNT_RST);
			filter_sample_interval_q <= INTV_W'(cwf_pkg::CWF_INTV_RST);
		end else if (wr_filt) begin
			if (avs_byteenable_i[0]) begin
				filter_sample_count_q <= avs_writedata_i[cwf_pkg::CWF_FILT_COUNT_LSB +: COUNT_W];
			end
			if (avs_byteenable_i[1]) begin
				filter_sample_interval_q <= avs_writedata_i[cwf_pkg::CWF_FILT_INTV_LSB +: INTV_W];
			end
		end
	end

	// Read data captured in the wait cycle; unmapped reads give zero
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && avs_waitrequest_o) begin
			avs_readdata_o <= 32'h0000_0000;
			unique case (avs_address_i)
				cwf_pkg::CWF_CTRL_ADDR: begin
					avs_readdata_o[cwf_pkg::CWF_CTRL_POWER_BIT]  <= power_on_q;
					avs_readdata_o[cwf_pkg::CWF_CTRL_WINDOW_BIT] <= window_en_q;
					avs_readdata_o[cwf_pkg::CWF_CTRL_STROBE_BIT] <= strobe_sel_q;
					avs_readdata_o[cwf_pkg::CWF_CTRL_INVERT_BIT] <= polarity_invert_q;
				end
				cwf_pkg::CWF_FILT_ADDR: begin
					avs_readdata_o[cwf_pkg::CWF_FILT_COUNT_LSB +: COUNT_W] <= filter_sample_count_q;
					avs_readdata_o[cwf_pkg::CWF_FILT_INTV_LSB +: INTV_W]   <= filter_sample_interval_q;
				end
				cwf_pkg::CWF_STATUS_ADDR: begin
					avs_readdata_o[cwf_pkg::CWF_STAT_COND_BIT] <= conditioned_output_o;
					avs_readdata_o[cwf_pkg::CWF_STAT_WIN_BIT]  <= window_stage_output_o;
					avs_readdata_o[cwf_pkg::CWF_STAT_RISE_BIT] <= rise_event_flag_o;
					avs_readdata_o[cwf_pkg::CWF_STAT_FALL_BIT] <= fall_event_flag_o;
				end
				default: begin
					avs_readdata_o <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_disabled_zero : assert property (!power_on_q && !window_en_q |->
		window_stage_output_o == polarity_invert_q)
		else $error("disabled comparator not held at zero");
	a_cont_equal : assert property (cont_mode |->
		(conditioned_output_o == window_stage_output_o && window_stage_output_o == polarity_out))
		else $error("continuous mode outputs differ from compare");
	a_window_hold : assert property ((window_en_q && !window_gate_i && !wr_ctrl) |=>
		$stable(window_stage_output_o))
		else $error("window output moved while gate low");
	a_window_follow : assert property ((window_en_q && window_gate_i) |=>
		(win_hold_q == $past(polarity_out)))
		else $error("window output missed gated sample");
	a_strobe_only : assert property ((strobe_sel_q && !sample_strobe_i && !wr_ctrl && !wr_filt) |=>
		$stable(filter_out))
		else $error("filter moved without strobe edge");
	a_rise_flag : assert property (rise_evt |=> rise_event_flag_o)
		else $error("rising edge did not set flag");
	a_fall_flag : assert property (fall_evt |=> fall_event_flag_o)
		else $error("falling edge did not set flag");
	a_bus_answer : assert property ((bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("bus access not answered after one wait");
	a_sample_bypass : assert property ((!window_en_q && filter_in_use) |->
		window_stage_output_o == polarity_out)
		else $error("sampled mode window stage not combinational");
	a_window_bypass : assert property (!window_en_q |->
		window_stage_output_o == polarity_out)
		else $error("unwindowed window stage not from compare path");
	a_filter_drives : assert property (filter_in_use |->
		conditioned_output_o == filter_out)
		else $error("filtered mode output not from filter");
	a_rise_sticky : assert property ((rise_event_flag_o && !clr_rise) |=>
		rise_event_flag_o)
		else $error("rise flag lost without clear");
	a_fall_sticky : assert property ((fall_event_flag_o && !clr_fall) |=>
		fall_event_flag_o)
		else $error("fall flag lost without clear");
	a_rise_clear : assert property ((clr_rise && !rise_evt) |=>
		!rise_event_flag_o)
		else $error("rise flag not cleared by write");
	a_fall_clear : assert property ((clr_fall && !fall_evt) |=>
		!fall_event_flag_o)
		else $error("fall flag not cleared by write");
	a_wait_idle : assert property (!bus_req |=>
		avs_waitrequest_o)
		else $error("wait request low with no access");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	c_windowed_filter : cover property (window_en_q && filter_in_use && sample_tick);
	c_strobe_sample : cover property (strobe_sel_q && sample_tick ##1 rise_evt);
	c_cont_fall : cover property (cont_mode && fall_evt);
	c_window_hold : cover property (window_en_q && !window_gate_i && window_stage_output_o);
	c_sampled_rise : cover property (!window_en_q && filter_in_use && rise_evt);
endmodule // cwf_top
`default_nettype wire

//--- dv/cwf_pwm_model.sv
// PWM-side partner: window gate and sample strobe.
// Assumes requests from the bench arrive on rising edges of mclk_i.
`timescale 1ns/1ns
`default_nettype none
module cwf_pwm_model (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic gate_on_i,
	input  wire logic pulse_req_i,
	output logic      window_gate_o,
	output logic      sample_strobe_o
);
	// ------------------------------------------------------------
	// Gate follows request, strobe is one cycle per request
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			window_gate_o   <= 1'b0;
			sample_strobe_o <= 1'b0;
		end else begin
			window_gate_o   <= gate_on_i;
			sample_strobe_o <= pulse_req_i && !sample_strobe_o;
		end
	end
endmodule // cwf_pwm_model
`default_nettype wire

//--- dv/comparator_window_filter_bench.sv
// Self-checking bench for the comparator window/filter block.
// Assumes the Avalon-MM timing and register map of the block's package.
`timescale 1ns/1ns
`default_nettype none
module comparator_window_filter_bench;
	typedef struct {
		logic [3:0]  ctrl;
		logic [15:0] filt;
		logic        raw;
		logic        gate;
		int          pulses;
		int          waits;
		logic        cond;
		logic        win;
	} cwf_row_type;
	localparam logic [3:0] CTRL = cwf_pkg::CWF_CTRL_ADDR;
	localparam logic [3:0] FILT = cwf_pkg::CWF_FILT_ADDR;
	localparam logic [3:0] STAT = cwf_pkg::CWF_STATUS_ADDR;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        wt;
	logic        raw = 1'b0;
	logic        gate_req = 1'b0;
	logic        pulse_req = 1'b0;
	logic        gate;
	logic        strobe;
	logic        win;
	logic        cond;
	logic        rise;
	logic        fall;
	logic [31:0] q;
	int          num_errors = 0;
	int          num_checks = 0;
	cwf_row_type rows [13] = '{
		'{4'h0, 16'h0000, 1'b1, 1'b0, 0, 4, 1'b0, 1'b0},
		'{4'h1, 16'h0000, 1'b1, 1'b0, 0, 4, 1'b1, 1'b1},
		'{4'h9, 16'h0000, 1'b1, 1'b0, 0, 4, 1'b0, 1'b0},
		'{4'h1, 16'h0003, 1'b1, 1'b0, 0, 4, 1'b1, 1'b1},
		'{4'h5, 16'h0001, 1'b1, 1'b0, 0, 20, 1'b0, 1'b1},
		'{4'h5, 16'h0001, 1'b1, 1'b0, 1, 4, 1'b1, 1'b1},
		'{4'h1, 16'h0401, 1'b1, 1'b0, 0, 10, 1'b1, 1'b1},
		'{4'h5, 16'h0002, 1'b1, 1'b0, 1, 4, 1'b0, 1'b1},
		'{4'h5, 16'h0002, 1'b1, 1'b0, 2, 4, 1'b1, 1'b1},
		'{4'h3, 16'h0000, 1'b1, 1'b0, 0, 6, 1'b0, 1'b0},
		'{4'h3, 16'h0000, 1'b1, 1'b1, 0, 6, 1'b1, 1'b1},
		'{4'h3, 16'h0201, 1'b1, 1'b1, 0, 10, 1'b1, 1'b1},
		'{4'h3, 16'h0203, 1'b1, 1'b1, 0, 20, 1'b1, 1'b1}
	};

	cwf_top cwf_top_inst (
		.mclk_i(mclk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_byteenable_i(4'hf), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wt), .raw_compare_result_i(raw), .window_gate_i(gate),
		.sample_strobe_i(strobe), .window_stage_output_o(win), .conditioned_output_o(cond),
		.rise_event_flag_o(rise), .fall_event_flag_o(fall)
	);
	cwf_pwm_model cwf_pwm_model_inst (
		.mclk_i(mclk), .rst_i(rst), .gate_on_i(gate_req), .pulse_req_i(pulse_req),
		.window_gate_o(gate), .sample_strobe_o(strobe)
	);

	initial begin
		forever #2 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		do begin
			@(posedge mclk);
		end while (wt !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	// Strobe off and count zero before any new setting
	task automatic apply_mode(input logic [3:0] c, input logic [15:0] f);
		bus(CTRL, 1'b1, {28'h0, c & 4'hb});
		bus(FILT, 1'b1, 32'h0);
		bus(FILT, 1'b1, {16'h0, f});
		bus(CTRL, 1'b1, {28'h0, c});
	endtask

	task automatic pulse();
		@(posedge mclk);
		pulse_req <= 1'b1;
		@(posedge mclk);
		pulse_req <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic drive_raw(input logic v, input int n);
		@(posedge mclk);
		raw <= v;
		repeat (n - 1) @(posedge mclk);
	endtask

	task report_and_stop;
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		report_and_stop;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge mclk);
		check(32'(wt), 32'h1);
		check(32'({cond, win, rise, fall}), 32'h0);
		rst <= 1'b0;
		bus(CTRL, 1'b0, 32'h0);
		check(q, 32'h0);
		bus(FILT, 1'b0, 32'h0);
		check(q, 32'h0);
		bus(STAT, 1'b0, 32'h0);
		check(q, 32'h0);
		bus(4'hc, 1'b1, 32'hffffffff);
		bus(4'hc, 1'b0, 32'h0);
		check(q, 32'h0);
		$display("reset and map test done");
		foreach (rows[i]) begin
			apply_mode(rows[i].ctrl, rows[i].filt);
			@(posedge mclk);
			raw      <= rows[i].raw;
			gate_req <= rows[i].gate;
			repeat (rows[i].pulses) pulse();
			repeat (rows[i].waits) @(posedge mclk);
			@(negedge mclk);
			check(32'(cond), 32'(rows[i].cond));
			check(32'(win), 32'(rows[i].win));
			$display("row %0d done", i);
		end
		bus(STAT, 1'b0, 32'h0);
		check(32'(q[2]), 32'h1);
		bus(STAT, 1'b1, 32'h0000000c);
		bus(STAT, 1'b0, 32'h0);
		check(32'(q[3:2]), 32'h0);
		drive_raw(1'b0, 20);
		bus(STAT, 1'b0, 32'h0);
		check(32'(q[3:0]), 32'h8);
		$display("event flag test done");
		apply_mode(4'h1, 16'h0203);
		drive_raw(1'b1, 4);
		drive_raw(1'b0, 2);
		drive_raw(1'b1, 4);
		drive_raw(1'b0, 6);
		@(negedge mclk);
		check(32'(cond), 32'h0);
		drive_raw(1'b1, 20);
		@(negedge mclk);
		check(32'(cond), 32'h1);
		apply_mode(4'h5, 16'h0001);
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		check(32'(cond), 32'h0);
		$display("restart and filter reset test done");
		apply_mode(4'h1, 16'h0000);
		@(posedge mclk);
		raw <= 1'b0;
		@(negedge mclk);
		check(32'(cond), 32'h0);
		check(32'(win), 32'h0);
		apply_mode(4'h3, 16'h0000);
		drive_raw(1'b1, 4);
		@(negedge mclk);
		check(32'(win), 32'h1);
		@(posedge mclk);
		gate_req <= 1'b0;
		drive_raw(1'b0, 6);
		@(negedge mclk);
		check(32'(win), 32'h1);
		$display("continuous and window hold test done");
		bus(CTRL, 1'b1, 32'h0);
		bus(FILT, 1'b1, 32'hffffffff);
		bus(FILT, 1'b0, 32'h0);
		check(q, 32'h0000ff07);
		bus(FILT, 1'b1, 32'h0);
		bus(CTRL, 1'b1, 32'hfffffffb);
		bus(CTRL, 1'b0, 32'h0);
		check(q, 32'h0000000b);
		$display("register field test done");
		report_and_stop;
	end
endmodule // comparator_window_filter_bench
`default_nettype wire
